/* File: logic/plr_blink.sv */
// free-running blink phase generator for the link indicator
// assumes a held reset input that restarts the phase
`timescale 1ns/1ps
`default_nettype none
module plr_blink #(
  parameter int unsigned HALF  = plr_pkg::BLINK_HALF_CYCLES,
  parameter int unsigned CNT_W = 20
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic hold,
  // phase out
  output var  logic phase
);
  import plr_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             phase_next;

  always_comb begin
    cnt_next   = cnt_reg + CNT_W'(1);
    phase_next = phase;
    if (hold) begin
      cnt_next   = '0;
      phase_next = 1'b0;
    end else if (cnt_reg >= CNT_W'(HALF - 1)) begin
      cnt_next   = '0;
      phase_next = ~phase;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      phase   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase   <= phase_next;
    end
  end
endmodule
`default_nettype wire

/* File: logic/plr_pkg.sv */
// package of the indicator, reset, shared-pin and strap block
// assumes a single 10 MHz bus clock and an AHB-Lite master with word accesses
package plr_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned RST_MIN_NS       = 1000;
  localparam int unsigned RST_MIN_CYCLES   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_NS    = 50000000;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PHY_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_IRQ_PIN_EN_BIT = 0;
  localparam int unsigned PHY_ISOLATE_BIT     = 8;
  localparam int unsigned IRQ_LINK_BIT        = 0;
  localparam int unsigned IRQ_SPEED_BIT       = 1;
  localparam int unsigned IRQ_COL_BIT         = 2;
  localparam int unsigned IRQ_W               = 3;

  // ==========================================================
  // reset values and indicator mode encodings
  localparam logic [4:0]       STRAP_ADDR_DEFAULT = 5'h01;
  localparam logic [IRQ_W-1:0] IRQ_RESET          = 3'h0;
  localparam logic [1:0]       LED_MODE_1         = 2'h1;
  localparam logic [1:0]       LED_MODE_2         = 2'h2;
  localparam logic [1:0]       LED_MODE_3         = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic link_good;
    logic speed_100;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic collision;
  } plr_line_state_type;

  typedef struct packed {
    logic link_indicator;
    logic speed_indicator;
    logic activity_collision_indicator;
  } plr_led_type;

endpackage

/* File: logic/plr_reset_sync.sv */
// reset synchroniser with a minimum internal reset stretch
// assumes hresetn may fall at any time and is released asynchronously
`timescale 1ns/1ps
`default_nettype none
module plr_reset_sync #(
  parameter int unsigned STRETCH = plr_pkg::RST_MIN_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // internal reset busy
  output var  logic rst_busy
);
  import plr_pkg::*;

  logic       meta_reg;
  logic       sync_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       busy_next;

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = 1'b0;
    if (!sync_reg) begin
      cnt_next  = 8'h00;
      busy_next = 1'b1;
    end else if (cnt_reg < 8'(STRETCH)) begin
      cnt_next  = cnt_reg + 8'h01;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      cnt_reg  <= 8'h00;
      rst_busy <= 1'b1;
    end else begin
      meta_reg <= 1'b1;
      sync_reg <= meta_reg;
      cnt_reg  <= cnt_next;
      rst_busy <= busy_next;
    end
  end
endmodule
`default_nettype wire

/* File: logic/plr_top.sv */
// indicator, reset, shared power-down/interrupt pin and strap logic
// assumes line state inputs synchronous to hclk and an AHB-Lite single-slave bus
// What this block does
// - mode 1: link indicator follows link, steady
// - modes 2,3: link on, blinks on activity
// - speed indicator on at 100, off at 10
// - mode 1: activity indicator on with traffic
// - mode 2: activity indicator shows collision
// - mode 3: may show full duplex instead
// - reset pulse of 1 us runs full reset
// - reset restores registers and resamples straps
// - shared pin defaults to active-low power-down input
// - interrupt mode: open drain, pulled low
// - straps sampled during reset select address and isolate
// - five-bit station address latched from straps
// - strapped zero isolates; written zero does not
// - default station address is one
`timescale 1ns/1ps
`default_nettype none
module plr_top #(
  parameter int unsigned BLINK_HALF = plr_pkg::BLINK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output var  logic                        hreadyout,
  output var  logic                        hresp,
  output var  logic [31:0]                 hrdata,
  // line state and indicator configuration
  input  wire plr_pkg::plr_line_state_type line_state,
  input  wire logic [1:0]                  led_mode,
  input  wire logic                        dup_sel,
  // indicators
  output var  plr_pkg::plr_led_type        leds,
  // straps
  input  wire logic [4:0]                  station_addr_strap,
  // shared power-down / interrupt pin
  input  wire logic                        powerdown_irq_pin_i,
  output var  logic                        powerdown_irq_pin_o,
  output var  logic                        powerdown_irq_pin_oe,
  // device state
  output var  logic                        powerdown,
  output var  logic                        isolate,
  output var  logic [4:0]                  station_addr,
  output var  logic                        irq
);
  import plr_pkg::*;

  // ==========================================================
  // reset and blink helpers
  logic rst_busy;
  logic blink_phase;

  plr_reset_sync #(.STRETCH(RST_MIN_CYCLES)) u_rst (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .rst_busy (rst_busy)
  );

  plr_blink #(.HALF(BLINK_HALF), .CNT_W(20)) u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hold    (rst_busy),
    .phase   (blink_phase)
  );

  // ==========================================================
  // indicator logic
  plr_led_type leds_next;
  logic        activity;

  assign activity = line_state.tx_active | line_state.rx_active;

  always_comb begin
    leds_next.speed_indicator = line_state.speed_100;
    case (led_mode)
      LED_MODE_2: begin
        leds_next.link_indicator = line_state.link_good & ~(activity & blink_phase);
        leds_next.activity_collision_indicator = line_state.collision;
      end
      LED_MODE_3: begin
        leds_next.link_indicator = line_state.link_good & ~(activity & blink_phase);
        leds_next.activity_collision_indicator = dup_sel ? line_state.full_duplex
                                                         : line_state.collision;
      end
      default: begin
        leds_next.link_indicator = line_state.link_good;
        leds_next.activity_collision_indicator = activity;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leds <= '0;
    end else begin
      leds <= leds_next;
    end
  end

  // ==========================================================
  // straps, control and interrupt state
  logic             irq_pin_en_reg;
  logic             irq_pin_en_next;
  logic [4:0]       addr_reg;
  logic [4:0]       addr_next;
  logic             isolate_reg;
  logic             isolate_next;
  logic             pd_reg;
  logic             pd_next;
  logic [IRQ_W-1:0] stat_reg;
  logic [IRQ_W-1:0] stat_next;
  logic [IRQ_W-1:0] mask_reg;
  logic [IRQ_W-1:0] mask_next;
  logic             link_q_reg;
  logic             speed_q_reg;
  logic             col_q_reg;
  logic [IRQ_W-1:0] events;

  // bus phase state
  logic             dp_wr_reg;
  logic             dp_wr_next;
  logic [7:0]       dp_addr_reg;
  logic [7:0]       dp_addr_next;
  logic [31:0]      rdata_next;
  logic             ap_take;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign ap_take = hsel & htrans[1] & hready & ~rst_busy;

  always_comb begin
    events                = '0;
    events[IRQ_LINK_BIT]  = line_state.link_good ^ link_q_reg;
    events[IRQ_SPEED_BIT] = line_state.speed_100 ^ speed_q_reg;
    events[IRQ_COL_BIT]   = line_state.collision & ~col_q_reg;
  end

  always_comb begin
    irq_pin_en_next = irq_pin_en_reg;
    addr_next       = addr_reg;
    isolate_next    = isolate_reg;
    mask_next       = mask_reg;
    stat_next       = stat_reg | events;
    pd_next         = ~irq_pin_en_reg & ~powerdown_irq_pin_i;
    dp_wr_next      = ap_take & hwrite;
    dp_addr_next    = ap_take ? haddr[7:0] : dp_addr_reg;
    rdata_next      = '0;
    if (rst_busy) begin
      irq_pin_en_next = 1'b0;
      addr_next       = station_addr_strap;
      isolate_next    = (station_addr_strap == 5'h00);
      mask_next       = IRQ_RESET;
      stat_next       = IRQ_RESET;
      pd_next         = 1'b0;
    end else begin
      if (dp_wr_reg) begin
        if (hit(dp_addr_reg, OFS_CTRL)) begin
          irq_pin_en_next = hwdata[CTRL_IRQ_PIN_EN_BIT];
        end
        if (hit(dp_addr_reg, OFS_PHY_CTRL)) begin
          addr_next = hwdata[4:0];
        end
        if (hit(dp_addr_reg, OFS_IRQ_MASK)) begin
          mask_next = hwdata[IRQ_W-1:0];
        end
        if (hit(dp_addr_reg, OFS_IRQ_STAT)) begin
          stat_next = (stat_reg & ~hwdata[IRQ_W-1:0]) | events;
        end
      end
      if (ap_take && !hwrite) begin
        if (hit(haddr[7:0], OFS_CTRL)) begin
          rdata_next[CTRL_IRQ_PIN_EN_BIT] = irq_pin_en_reg;
        end
        if (hit(haddr[7:0], OFS_PHY_CTRL)) begin
          rdata_next[4:0]            = addr_reg;
          rdata_next[PHY_ISOLATE_BIT] = isolate_reg;
        end
        if (hit(haddr[7:0], OFS_STATUS)) begin
          rdata_next[5:0] = line_state;
          rdata_next[6]   = pd_reg;
          rdata_next[7]   = isolate_reg;
        end
        if (hit(haddr[7:0], OFS_IRQ_STAT)) begin
          rdata_next[IRQ_W-1:0] = stat_reg;
        end
        if (hit(haddr[7:0], OFS_IRQ_MASK)) begin
          rdata_next[IRQ_W-1:0] = mask_reg;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pin_en_reg <= 1'b0;
      addr_reg       <= STRAP_ADDR_DEFAULT;
      isolate_reg    <= 1'b0;
      pd_reg         <= 1'b0;
      stat_reg       <= IRQ_RESET;
      mask_reg       <= IRQ_RESET;
      link_q_reg     <= 1'b0;
      speed_q_reg    <= 1'b0;
      col_q_reg      <= 1'b0;
      dp_wr_reg      <= 1'b0;
      dp_addr_reg    <= 8'h00;
      hrdata         <= 32'h0000_0000;
    end else begin
      irq_pin_en_reg <= irq_pin_en_next;
      addr_reg       <= addr_next;
      isolate_reg    <= isolate_next;
      pd_reg         <= pd_next;
      stat_reg       <= stat_next;
      mask_reg       <= mask_next;
      link_q_reg     <= line_state.link_good;
      speed_q_reg    <= line_state.speed_100;
      col_q_reg      <= line_state.collision;
      dp_wr_reg      <= dp_wr_next;
      dp_addr_reg    <= dp_addr_next;
      hrdata         <= rdata_next;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout            = ~rst_busy;
  assign hresp                = 1'b0;
  assign irq                  = |(stat_reg & mask_reg);
  assign powerdown_irq_pin_o  = 1'b0;
  assign powerdown_irq_pin_oe = irq_pin_en_reg & irq;
  assign powerdown            = pd_reg;
  assign isolate              = isolate_reg;
  assign station_addr         = addr_reg;

  // ==========================================================
  // assertions
  // cycles of internal reset seen since release
  logic [7:0] busy_cnt_reg;
  logic [7:0] busy_cnt_next;

  always_comb begin
    busy_cnt_next = busy_cnt_reg;
    if (rst_busy && (busy_cnt_reg != 8'hFF)) begin
      busy_cnt_next = busy_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  chk_link_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (led_mode == LED_MODE_1) |=> leds.link_indicator == $past(line_state.link_good))
    else $error("link indicator wrong in mode 1");

  chk_link_blink: assert property (@(posedge hclk) disable iff (!hresetn)
    (led_mode[1] && line_state.link_good && !activity) |=> leds.link_indicator)
    else $error("link indicator off while link good and idle");

  chk_speed_led: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> leds.speed_indicator == $past(line_state.speed_100))
    else $error("speed indicator does not follow speed");

  chk_act_mode1: assert property (@(posedge hclk) disable iff (!hresetn)
    (led_mode == LED_MODE_1 && activity) |=> leds.activity_collision_indicator)
    else $error("activity indicator off with traffic");

  chk_col_mode2: assert property (@(posedge hclk) disable iff (!hresetn)
    (led_mode == LED_MODE_2) |=> leds.activity_collision_indicator == $past(line_state.collision))
    else $error("collision indicator wrong in mode 2");

  chk_dup_mode3: assert property (@(posedge hclk) disable iff (!hresetn)
    (led_mode == LED_MODE_3 && dup_sel) |=> leds.activity_collision_indicator == $past(line_state.full_duplex))
    else $error("duplex indicator wrong in mode 3");

  chk_reset_len: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(rst_busy) |-> busy_cnt_reg >= 8'(RST_MIN_CYCLES))
    else $error("internal reset too short");

  chk_strap_take: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(rst_busy) |-> station_addr == $past(station_addr_strap))
    else $error("strap address not latched at release");

  chk_isolate_strap: assert property (@(posedge hclk) disable iff (!hresetn)
    !rst_busy |=> isolate == $past(isolate))
    else $error("isolate changed outside reset");

  chk_pin_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rst_busy && !dp_wr_reg && irq_pin_en_reg && |(mask_reg & events))
      |=> powerdown_irq_pin_oe && !powerdown_irq_pin_o)
    else $error("interrupt pin not pulled low");

  chk_pd_input: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rst_busy && !irq_pin_en_reg && !powerdown_irq_pin_i) |=> powerdown)
    else $error("power-down not entered on low pin");

  chk_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rst_busy && events[IRQ_COL_BIT]) |=> stat_reg[IRQ_COL_BIT])
    else $error("collision event lost");

endmodule
`default_nettype wire

/* File: test/plr_board.sv */
// board model: strap resistors and the host side of the shared pin
// assumes weak pull-up on strap bit 0, pull-downs on bits 4..1, pull-up on the pin
`timescale 1ns/1ps
`default_nettype none
module plr_board (
  // strap drive from the bench
  input  wire logic       strap_en,
  input  wire logic [4:0] strap_val,
  // host side of the shared pin
  input  wire logic       host_pd_low,
  // device side of the shared pin
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  // levels seen by the device
  output var  logic [4:0] station_addr_strap,
  output var  logic       pin_i
);
  // ==========================================================
  // wire levels
  always_comb begin
    station_addr_strap = strap_en ? strap_val : 5'h01;
    pin_i              = !((pin_oe && !pin_o) || host_pd_low);
  end
endmodule
`default_nettype wire

/* File: test/plr_top_tb.sv */
// self-checking bench of the indicator, reset, shared-pin and strap block
// assumes plr_pkg, plr_top and plr_board compiled before it
`timescale 1ns/1ps
`default_nettype none
module plr_top_tb;
  import plr_pkg::*;
  // ==========================================================
  // signals
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0;
  logic               hreadyout, hresp, irq, powerdown, isolate;
  logic [31:0]        hrdata, rd;
  plr_line_state_type ls = 6'h00;
  logic [1:0]         led_mode = 2'h1;
  logic               dup_sel = 1'b0;
  plr_led_type        leds;
  logic [4:0]         strap_pins, station_addr, strap_val = 5'h00;
  logic               strap_en = 1'b0, host_pd_low = 1'b0;
  logic               pin_i, pin_o, pin_oe;
  int                 error_cnt = 0, tests_run = 0;

  plr_top #(.BLINK_HALF(4)) i_plr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_state(ls), .led_mode(led_mode),
    .dup_sel(dup_sel), .leds(leds), .station_addr_strap(strap_pins), .powerdown_irq_pin_i(pin_i),
    .powerdown_irq_pin_o(pin_o), .powerdown_irq_pin_oe(pin_oe), .powerdown(powerdown),
    .isolate(isolate), .station_addr(station_addr), .irq(irq));

  plr_board i_plr_board (.strap_en(strap_en), .strap_val(strap_val), .host_pd_low(host_pd_low),
    .pin_o(pin_o), .pin_oe(pin_oe), .station_addr_strap(strap_pins), .pin_i(pin_i));

  // ==========================================================
  // clock and watchdog
  initial begin
    forever #50 hclk = ~hclk;
  end

  initial begin
    #(100 * 20000);
    error_cnt++;
    wrap_up();
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic wait3();
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic do_reset(input logic en, input logic [4:0] s);
    @(posedge hclk);
    strap_en  <= en;
    strap_val <= s;
    hresetn   <= 1'b0;
    repeat (RST_MIN_CYCLES) @(posedge hclk);
    @(negedge hclk);
    chk(hreadyout, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    do @(negedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic led_case(input logic [1:0] m, input logic d, input logic [5:0] s, input logic [2:0] exp);
    @(posedge hclk);
    led_mode <= m;
    dup_sel  <= d;
    ls       <= s;
    wait3();
    chk(leds, exp);
  endtask

  task automatic blink(input logic [1:0] m, input logic [5:0] s, input int lo, input int hi);
    int c;
    @(posedge hclk);
    led_mode <= m;
    ls       <= s;
    repeat (2) @(posedge hclk);
    c = 0;
    repeat (16) begin
      @(negedge hclk);
      c += (leds.link_indicator === 1'b1);
    end
    chk(c >= lo && c <= hi, 32'h1);
  endtask

  task automatic wrap_up();
    $display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    do_reset(1'b0, 5'h00);
    chk(station_addr, 32'h01);
    chk(isolate, 32'h0);
    $display("test default straps done");
    led_case(2'h1, 1'b0, 6'b100000, 3'b100);
    led_case(2'h1, 1'b0, 6'b010010, 3'b011);
    led_case(2'h2, 1'b0, 6'b100001, 3'b101);
    led_case(2'h2, 1'b1, 6'b101000, 3'b100);
    led_case(2'h3, 1'b1, 6'b101000, 3'b101);
    led_case(2'h3, 1'b1, 6'b100001, 3'b100);
    led_case(2'h3, 1'b0, 6'b110001, 3'b111);
    led_case(2'h2, 1'b0, 6'b010000, 3'b010);
    led_case(2'h0, 1'b0, 6'b100010, 3'b101);
    blink(2'h2, 6'b100100, 8, 8);
    blink(2'h3, 6'b100010, 8, 8);
    blink(2'h1, 6'b100100, 16, 16);
    $display("test indicators done");
    @(posedge hclk);
    host_pd_low <= 1'b1;
    wait3();
    chk(powerdown, 32'h1);
    @(posedge hclk);
    host_pd_low <= 1'b0;
    wait3();
    chk(powerdown, 32'h0);
    $display("test power-down pin done");
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_IRQ_STAT, 32'h7);
    wait3();
    chk({irq, pin_oe}, 32'h0);
    @(posedge hclk);
    ls <= 6'b000000;
    wait3();
    chk({irq, pin_oe, pin_i, pin_o}, 32'hC);
    chk(powerdown, 32'h0);
    rdc(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    wait3();
    chk({irq, pin_oe}, 32'h0);
    wr(OFS_IRQ_STAT, 32'h1);
    rdc(OFS_IRQ_STAT, 32'h0);
    rdc(8'h20, 32'h0);
    $display("test interrupt pin done");
    wr(OFS_PHY_CTRL, 32'h0);
    wait3();
    chk({isolate, station_addr}, 32'h00);
    wr(OFS_PHY_CTRL, 32'h1F);
    rdc(OFS_PHY_CTRL, 32'h1F);
    $display("test address write done");
    do_reset(1'b1, 5'h00);
    chk({isolate, station_addr}, 32'h20);
    rdc(OFS_IRQ_MASK, 32'h0);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_STATUS, 32'h80);
    @(posedge hclk);
    strap_en <= 1'b0;
    wait3();
    chk(station_addr, 32'h00);
    do_reset(1'b1, 5'h1A);
    chk({isolate, station_addr}, 32'h1A);
    rdc(OFS_PHY_CTRL, 32'h1A);
    $display("test strap reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
